// file: asram_defs.vh
`ifndef ASRAM_DEFS_VH
`define ASRAM_DEFS_VH

// Clock period in ns
`define ASRAM_CLK_NS 20
// Timing of the 55 ns grade, in ns
`define ASRAM_CYCLE_NS 55
`define ASRAM_ACCESS_NS 55
`define ASRAM_GATE_ACCESS_NS 20
`define ASRAM_SEL_TO_END_NS 45
`define ASRAM_ADDR_TO_END_NS 45
`define ASRAM_DATA_SETUP_NS 25
`define ASRAM_FLOAT_NS 20
// Least times round up to whole cycles
`define ASRAM_CEIL(t) (((t) + `ASRAM_CLK_NS - 1) / `ASRAM_CLK_NS)
`define ASRAM_ACCESS_CYC `ASRAM_CEIL(`ASRAM_ACCESS_NS + 2 * `ASRAM_CLK_NS)
`define ASRAM_WR_PULSE_NS (`ASRAM_SEL_TO_END_NS + `ASRAM_FLOAT_NS)
`define ASRAM_WR_CYC `ASRAM_CEIL(`ASRAM_WR_PULSE_NS + `ASRAM_DATA_SETUP_NS)
`define ASRAM_CYCLE_CYC `ASRAM_CEIL(`ASRAM_CYCLE_NS)
// Bus widths
`define ASRAM_AW 17
`define ASRAM_DW 8

`endif

// file: asram_host.v
// Function
// - Write only while selected and strobe low
// - Data held past the write-ending edge
// - Strobe write lengthened by float plus setup
// - Host never drives while memory drives
// - Read keeps strobe high, selected, gate low
// - Address valid before select goes active
// - Address stable through the whole write
// - Write data valid long before write end
`timescale 1ns/1ns
`default_nettype none
`include "asram_defs.vh"

module asram_host
(
   input  wire                  clock_i,
   input  wire                  rst_i,
   input  wire                  req_valid_i,
   input  wire                  req_write_i,
   input  wire [`ASRAM_AW-1:0]  req_addr_i,
   input  wire [`ASRAM_DW-1:0]  req_wdata_i,
   output reg                   req_ready_o,
   output reg                   rd_valid_o,
   output reg  [`ASRAM_DW-1:0]  rd_data_o,
   output reg  [`ASRAM_AW-1:0]  address_pins_o,
   output reg                   select_active_low_o,
   output reg                   select_active_high_o,
   output reg                   gate_n_o,
   output reg                   strobe_n_o,
   output reg  [`ASRAM_DW-1:0]  data_pins_o,
   output reg                   data_pins_oe_o,
   input  wire [`ASRAM_DW-1:0]  data_pins_i
);

   ////////////////////////////////////////////////////////////////////////
   // Controller states
   localparam [2:0] ST_IDLE  = 3'd0;
   localparam [2:0] ST_SETUP = 3'd1;
   localparam [2:0] ST_READ  = 3'd2;
   localparam [2:0] ST_WRITE = 3'd3;
   localparam [2:0] ST_END   = 3'd4;
   localparam [2:0] ST_GAP   = 3'd5;

   ////////////////////////////////////////////////////////////////////////
   // Counts arrive as integers; a byte holds every grade's count
   localparam integer ACCESS_INT = `ASRAM_ACCESS_CYC;
   localparam integer WR_INT     = `ASRAM_WR_CYC;
   localparam integer CYCLE_INT  = `ASRAM_CYCLE_CYC;
   localparam [7:0]   ACCESS_CYC = ACCESS_INT[7:0];
   localparam [7:0]   WR_CYC     = WR_INT[7:0];
   localparam [7:0]   CYCLE_CYC  = CYCLE_INT[7:0];

   ////////////////////////////////////////////////////////////////////////
   reg [2:0]            state_reg;
   reg [7:0]            cnt_reg;
   reg                  write_reg;
   reg [`ASRAM_DW-1:0]  sync1_reg;
   reg [`ASRAM_DW-1:0]  sync2_reg;
   wire                 take_req;

   ////////////////////////////////////////////////////////////////////////
   // Shared by every timed state
   function reached;
      input [7:0] count;
      input [7:0] limit;
      begin
         reached = (count >= limit);
      end
   endfunction

   function [7:0] count_up;
      input [7:0] count;
      begin
         // Wraps at 255; no state counts that far
         count_up = count + 8'h01;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // A request counts only in idle with ready shown
   assign take_req = req_valid_i && req_ready_o && (state_reg == ST_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // Pin inputs pass two flops; access time covers the added latency
   // The byte crosses unguarded; the memory holds it still by then
   always @(posedge clock_i)
   begin
      sync1_reg <= data_pins_i;
      sync2_reg <= sync1_reg;
   end

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         // Bus idle: deselected, gate and strobe high, pins released
         state_reg            <= ST_IDLE;
         cnt_reg              <= 8'h00;
         write_reg            <= 1'b0;
         req_ready_o          <= 1'b0;
         rd_valid_o           <= 1'b0;
         rd_data_o            <= 8'h00;
         address_pins_o       <= 17'h0_0000;
         select_active_low_o  <= 1'b1;
         select_active_high_o <= 1'b0;
         gate_n_o             <= 1'b1;
         strobe_n_o           <= 1'b1;
         data_pins_o          <= 8'h00;
         data_pins_oe_o       <= 1'b0;
      end
      else
      begin
         // Read answer is a one-cycle pulse
         rd_valid_o <= 1'b0;
         case (state_reg)
            ST_IDLE:
            begin
               // Ready shows one edge after idle is reached
               req_ready_o <= 1'b1;
               if (take_req)
               begin
                  req_ready_o    <= 1'b0;
                  address_pins_o <= req_addr_i;
                  data_pins_o    <= req_wdata_i;
                  write_reg      <= req_write_i;
                  state_reg      <= ST_SETUP;
               end
            end
            ST_SETUP:
            begin
               select_active_low_o  <= 1'b0;
               select_active_high_o <= 1'b1;
               cnt_reg              <= 8'h01;
               if (write_reg)
               begin
                  strobe_n_o     <= 1'b0;
                  data_pins_oe_o <= 1'b1;
                  state_reg      <= ST_WRITE;
               end
               else
               begin
                  gate_n_o  <= 1'b0;
                  state_reg <= ST_READ;
               end
            end
            ST_READ:
            begin
               cnt_reg <= count_up(cnt_reg);
               if (reached(cnt_reg, ACCESS_CYC))
               begin
                  // Byte at the given address
                  // Synchronised copy, two edges old
                  rd_data_o  <= sync2_reg;
                  rd_valid_o <= 1'b1;
                  gate_n_o   <= 1'b1;
                  state_reg  <= ST_END;
               end
            end
            ST_WRITE:
            begin
               cnt_reg <= count_up(cnt_reg);
               if (reached(cnt_reg, WR_CYC))
               begin
                  strobe_n_o <= 1'b1;
                  state_reg  <= ST_END;
               end
            end
            ST_END:
            begin
               // Data and address held a cycle
               data_pins_oe_o       <= 1'b0;
               // Gap counts afresh, not from the last state
               cnt_reg              <= 8'h01;
               select_active_low_o  <= 1'b1;
               select_active_high_o <= 1'b0;
               state_reg            <= ST_GAP;
            end
            ST_GAP:
            begin
               cnt_reg <= count_up(cnt_reg);
               if (reached(cnt_reg, CYCLE_CYC))
               begin
                  state_reg <= ST_IDLE;
               end
            end
            default:
            begin
               // Unused codes fall back to idle
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// file: asram_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "asram_defs.vh"
module asram_mem_model
(
   input  wire logic [16:0] addr_i,
   input  wire logic        sel_n_i,
   input  wire logic        sel_i,
   input  wire logic        gate_n_i,
   input  wire logic        strobe_n_i,
   input  wire logic [7:0]  pins_i,
   output var  logic [7:0]  drive_o
);
   logic [7:0] mem [0:131071];
   time        since_t = 0;
   wire        wr = !sel_n_i && sel_i && !strobe_n_i;
   wire        rd = !sel_n_i && sel_i && !gate_n_i && strobe_n_i;
   always @(negedge wr)
      mem[addr_i] = pins_i;
   always @(addr_i or rd)
      since_t = $time;
   // Late answer only
   // Floating bus toggles, so an early read sees the last byte and its complement in turn
   // Updates sit off the clock edges so sampling never races them
   initial
   begin
      drive_o = 8'h00;
      #3;
      forever
      begin
         if (rd === 1'b1 && $time - since_t >= `ASRAM_ACCESS_NS)
            drive_o = mem[addr_i];
         else
            drive_o = ~drive_o;
         #5;
      end
   end
endmodule
`default_nettype wire

// file: asram_host_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module asram_host_chk
(
   input wire logic        clock_i,
   input wire logic        rst_i,
   input wire logic        rd_valid_o,
   input wire logic [16:0] address_pins_o,
   input wire logic        select_active_low_o,
   input wire logic        gate_n_o,
   input wire logic        strobe_n_o,
   input wire logic        data_pins_oe_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   a_read_form: assert property (!gate_n_o |-> strobe_n_o)
      else $error("gate low with strobe low");
   a_no_fight: assert property (!gate_n_o |-> !data_pins_oe_o)
      else $error("host drives during read");
   a_write_len: assert property ($fell(strobe_n_o) |->
      (!strobe_n_o && data_pins_oe_o)[*5])
      else $error("write pulse too short");
   a_data_hold: assert property ($rose(strobe_n_o) |->
      data_pins_oe_o)
      else $error("data released at write end");
   a_addr_stay: assert property (!strobe_n_o |=>
      $stable(address_pins_o))
      else $error("address moved in write");
   a_sel_first: assert property (!strobe_n_o |->
      !select_active_low_o)
      else $error("strobe without select");
   a_cycle_min: assert property ($fell(select_active_low_o) |->
      !select_active_low_o[*3])
      else $error("cycle too short");
   a_read_done: assert property ($fell(gate_n_o) |->
      ##[2:8] rd_valid_o)
      else $error("read answer late");
   a_addr_first: assert property ($fell(select_active_low_o) |->
      $stable(address_pins_o))
      else $error("address moved as select fell");
endmodule
bind asram_host asram_host_chk chk_u (.clock_i(clock_i), .rst_i(rst_i),
   .rd_valid_o(rd_valid_o), .address_pins_o(address_pins_o),
   .select_active_low_o(select_active_low_o), .gate_n_o(gate_n_o),
   .strobe_n_o(strobe_n_o), .data_pins_oe_o(data_pins_oe_o));
`default_nettype wire

// file: asram_host_bench.sv
`timescale 1ns/1ns
`default_nettype none
module asram_host_bench;
   logic clock_i = 0, rst_i = 1, req_valid_i = 0, req_write_i = 0;
   logic [16:0] req_addr_i = 0, addr;
   logic [7:0]  req_wdata_i = 0, rd_data_o, dout, drive;
   logic        req_ready_o, rd_valid_o, sn, s, g, w, oe;
   int          n_errors = 0, cmp_count = 0, ticks = 0;
   wire  [7:0]  bus = oe ? dout : drive;
   asram_host dut_u (.clock_i(clock_i), .rst_i(rst_i),
      .req_valid_i(req_valid_i), .req_write_i(req_write_i),
      .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
      .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o),
      .rd_data_o(rd_data_o), .address_pins_o(addr),
      .select_active_low_o(sn), .select_active_high_o(s),
      .gate_n_o(g), .strobe_n_o(w), .data_pins_o(dout),
      .data_pins_oe_o(oe), .data_pins_i(bus));
   asram_mem_model mem_u (.addr_i(addr), .sel_n_i(sn), .sel_i(s),
      .gate_n_i(g), .strobe_n_i(w), .pins_i(bus), .drive_o(drive));
   initial forever #10 clock_i = ~clock_i;
   task give_verdict;
      if (n_errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clock_i)
   begin
      ticks <= ticks + 1;
      if (ticks == 3000)
      begin
         n_errors++;
         give_verdict;
      end
   end
   task check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task access(input logic wr, input logic [16:0] a, input logic [7:0] d);
      for (int i = 0; i < 40 && req_ready_o !== 1'b1; i++)
         @(negedge clock_i);
      check({7'h00, req_ready_o}, 8'h01);
      {req_valid_i, req_write_i, req_addr_i, req_wdata_i} = {1'b1, wr, a, d};
      @(negedge clock_i);
      req_valid_i = 0;
   endtask
   task read_chk(input logic [16:0] a, input logic [7:0] exp);
      access(0, a, 8'h00);
      for (int i = 0; i < 40 && rd_valid_o !== 1'b1; i++)
         @(negedge clock_i);
      check({7'h00, rd_valid_o}, 8'h01);
      check(rd_data_o, exp);
   endtask
   task t_ends;
      access(1, 17'h0_0000, 8'hA5);
      access(1, 17'h1_FFFF, 8'h5A);
      read_chk(17'h0_0000, 8'hA5);
      read_chk(17'h1_FFFF, 8'h5A);
   endtask
   task t_overwrite;
      access(1, 17'h0_0155, 8'h0F);
      access(1, 17'h0_0155, 8'hF0);
      read_chk(17'h0_0155, 8'hF0);
      read_chk(17'h0_0000, 8'hA5);
   endtask
   initial
   begin
      repeat (16) @(negedge clock_i);
      rst_i = 0;
      t_ends;
      t_overwrite;
      give_verdict;
   end
endmodule
`default_nettype wire
